// ### shared/cib_defines.svh
// constants shared by the instruction execution block
`ifndef CIB_DEFINES_SVH
`define CIB_DEFINES_SVH

`define CIB_PC_W          13
`define CIB_ADDR_W        8
`define CIB_DATA_W        8
`define CIB_BIT_SEL_W     3
`define CIB_CALL_PC_INC   13'h0001
`define CIB_BYTE_ZERO     8'h00
`define CIB_BIT_ONE       8'h01
`define CIB_BCD_DIGIT_MAX 4'h9
`define CIB_BCD_FIX_LO    8'h06
`define CIB_BCD_FIX_HI    8'h60
`define CIB_BCD_FIX_BOTH  8'h66

`endif

// ### shared/cib_pkg.sv
// types for the instruction execution block
`default_nettype none

package cib_pkg;

    // operation codes presented by the decode stage
    typedef enum logic [2:0] {
        CIB_OP_CALL        = 3'h0,
        CIB_OP_WIPE_BYTE   = 3'h1,
        CIB_OP_WIPE_BIT    = 3'h2,
        CIB_OP_WDT_CLR     = 3'h3,
        CIB_OP_INVERT      = 3'h4,
        CIB_OP_INVERT_TO_W = 3'h5,
        CIB_OP_BCD_ADJUST  = 3'h6
    } cib_op_type;

    // sequencer states, gray coded along idle-read-exec-writeback
    typedef enum logic [2:0] {
        CIB_ST_IDLE = 3'h0,
        CIB_ST_RD   = 3'h1,
        CIB_ST_EXE  = 3'h3,
        CIB_ST_WB   = 3'h2,
        CIB_ST_CALL = 3'h6
    } cib_state_type;

endpackage : cib_pkg

`default_nettype wire

// ### verilog/cib_bcd_adjust.sv
// decimal adjust of the working register after a bcd addition
`include "cib_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cib_bcd_adjust (
    input  wire logic [`CIB_DATA_W-1:0] acc_in,
    input  wire logic                   nibble_ov_in,
    input  wire logic                   high_ov_in,
    output logic      [`CIB_DATA_W-1:0] result_out,
    output logic                        carry_out
);
    logic                 lo_fix;
    logic                 hi_fix;
    logic [`CIB_DATA_W:0] lo_sum;

    // low digit first, its carry may push the high digit past nine
    assign lo_fix     = (acc_in[3:0] > `CIB_BCD_DIGIT_MAX) || nibble_ov_in;
    assign lo_sum     = {1'b0, acc_in} + (lo_fix ? {1'b0, `CIB_BCD_FIX_LO} : {1'b0, `CIB_BYTE_ZERO});
    assign hi_fix     = (lo_sum[7:4] > `CIB_BCD_DIGIT_MAX) || high_ov_in || lo_sum[`CIB_DATA_W];
    // total added is always one of 00, 06, 60 or 66 modulo 256
    assign result_out = lo_sum[`CIB_DATA_W-1:0] + (hi_fix ? `CIB_BCD_FIX_HI : `CIB_BYTE_ZERO);
    assign carry_out  = hi_fix;

endmodule : cib_bcd_adjust

`default_nettype wire

// ### verilog/cib_exec.sv
// execution sequencer for call, wipe, watchdog clear, invert and bcd adjust operations
`include "cib_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cib_exec (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    input  wire logic                      op_valid,
    output logic                           op_ready,
    input  wire cib_pkg::cib_op_type       op_code,
    input  wire logic [`CIB_ADDR_W-1:0]    op_mem_addr,
    input  wire logic [`CIB_BIT_SEL_W-1:0] op_bit_sel,
    input  wire logic [`CIB_PC_W-1:0]      op_call_target,
    input  wire logic [`CIB_PC_W-1:0]      pc_now,
    input  wire logic [`CIB_DATA_W-1:0]    working_register,
    input  wire logic                      nibble_overflow_flag,
    input  wire logic                      high_digit_outflow,
    output logic      [`CIB_ADDR_W-1:0]    mem_addr,
    output logic                           mem_rd,
    input  wire logic [`CIB_DATA_W-1:0]    mem_rdata,
    output logic                           mem_wr,
    output logic      [`CIB_DATA_W-1:0]    mem_wdata,
    output logic                           stack_push,
    output logic      [`CIB_PC_W-1:0]      stack_data,
    output logic                           pc_load,
    output logic      [`CIB_PC_W-1:0]      pc_target,
    output logic                           wreg_wr,
    output logic      [`CIB_DATA_W-1:0]    wreg_wdata,
    output logic                           zero_wr,
    output logic                           result_null_flag,
    output logic                           carry_wr,
    output logic                           carry_next,
    output logic                           watchdog_count_clr,
    output logic                           expiry_flag_clr,
    output logic                           sleep_flag_clr,
    output logic                           op_done
);
    import cib_pkg::*;

    cib_state_type              state_reg,     state_next;
    cib_op_type                 op_reg,        op_next;
    logic [`CIB_BIT_SEL_W-1:0]  bit_reg,       bit_next;
    logic [`CIB_PC_W-1:0]       tgt_reg,       tgt_next;
    logic [`CIB_ADDR_W-1:0]     mem_addr_reg,  mem_addr_next;
    logic                       mem_rd_reg,    mem_rd_next;
    logic                       mem_wr_reg,    mem_wr_next;
    logic [`CIB_DATA_W-1:0]     mem_wdata_reg, mem_wdata_next;
    logic                       push_reg,      push_next;
    logic [`CIB_PC_W-1:0]       sdata_reg,     sdata_next;
    logic                       pcld_reg,      pcld_next;
    logic [`CIB_PC_W-1:0]       pctgt_reg,     pctgt_next;
    logic                       wreg_wr_reg,   wreg_wr_next;
    logic [`CIB_DATA_W-1:0]     wreg_wd_reg,   wreg_wd_next;
    logic                       zero_wr_reg,   zero_wr_next;
    logic                       zero_val_reg,  zero_val_next;
    logic                       carry_wr_reg,  carry_wr_next;
    logic                       carry_val_reg, carry_val_next;
    logic                       wdt_clr_reg,   wdt_clr_next;
    logic [`CIB_DATA_W-1:0]     bcd_result;
    logic                       bcd_carry;
    logic [`CIB_DATA_W-1:0]     inv_data;
    logic [`CIB_DATA_W-1:0]     bit_mask;
    logic                       take;

    // the adjust works on the live working register, so no operand fetch is needed
    cib_bcd_adjust u_bcd (
        .acc_in       (working_register),
        .nibble_ov_in (nibble_overflow_flag),
        .high_ov_in   (high_digit_outflow),
        .result_out   (bcd_result),
        .carry_out    (bcd_carry)
    );

    // handshake is combinational, one operation in flight at a time
    assign op_ready = (state_reg == CIB_ST_IDLE);
    assign op_done  = (state_reg == CIB_ST_WB);
    assign take     = op_valid && op_ready;
    assign inv_data = ~mem_rdata;
    assign bit_mask = `CIB_BIT_ONE << bit_reg;

    // next-state and next-output computation
    always_comb begin
        state_next     = state_reg;
        op_next        = op_reg;
        bit_next       = bit_reg;
        tgt_next       = tgt_reg;
        mem_addr_next  = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        sdata_next     = sdata_reg;
        pctgt_next     = pctgt_reg;
        wreg_wd_next   = wreg_wd_reg;
        zero_val_next  = zero_val_reg;
        carry_val_next = carry_val_reg;
        mem_rd_next    = 1'b0;
        mem_wr_next    = 1'b0;
        push_next      = 1'b0;
        pcld_next      = 1'b0;
        wreg_wr_next   = 1'b0;
        zero_wr_next   = 1'b0;
        carry_wr_next  = 1'b0;
        wdt_clr_next   = 1'b0;
        case (state_reg)
            CIB_ST_IDLE: begin
                if (op_valid) begin
                    op_next       = op_code;
                    bit_next      = op_bit_sel;
                    tgt_next      = op_call_target;
                    mem_addr_next = op_mem_addr;
                    case (op_code)
                        CIB_OP_CALL: begin
                            push_next  = 1'b1;
                            sdata_next = pc_now + `CIB_CALL_PC_INC;
                            state_next = CIB_ST_CALL;
                        end
                        CIB_OP_WIPE_BYTE: begin
                            mem_wr_next    = 1'b1;
                            mem_wdata_next = `CIB_BYTE_ZERO;
                            state_next     = CIB_ST_WB;
                        end
                        CIB_OP_WDT_CLR: begin
                            wdt_clr_next = 1'b1;
                            state_next   = CIB_ST_WB;
                        end
                        CIB_OP_BCD_ADJUST: begin
                            mem_wr_next    = 1'b1;
                            mem_wdata_next = bcd_result;
                            carry_wr_next  = 1'b1;
                            carry_val_next = bcd_carry;
                            state_next     = CIB_ST_WB;
                        end
                        default: begin
                            // bit wipe and both inverts need the operand byte first
                            mem_rd_next = 1'b1;
                            state_next  = CIB_ST_RD;
                        end
                    endcase
                end
            end
            CIB_ST_RD: begin
                state_next = CIB_ST_EXE;
            end
            CIB_ST_EXE: begin
                state_next = CIB_ST_WB;
                case (op_reg)
                    CIB_OP_WIPE_BIT: begin
                        mem_wr_next    = 1'b1;
                        mem_wdata_next = mem_rdata & ~bit_mask;
                    end
                    CIB_OP_INVERT: begin
                        mem_wr_next    = 1'b1;
                        mem_wdata_next = inv_data;
                        zero_wr_next   = 1'b1;
                        zero_val_next  = (inv_data == `CIB_BYTE_ZERO);
                    end
                    default: begin
                        wreg_wr_next  = 1'b1;
                        wreg_wd_next  = inv_data;
                        zero_wr_next  = 1'b1;
                        zero_val_next = (inv_data == `CIB_BYTE_ZERO);
                    end
                endcase
            end
            CIB_ST_CALL: begin
                // second cycle of the call: the dummy slot while the new address loads
                pcld_next  = 1'b1;
                pctgt_next = tgt_reg;
                state_next = CIB_ST_WB;
            end
            CIB_ST_WB: begin
                state_next = CIB_ST_IDLE;
            end
            default: begin
                state_next = CIB_ST_IDLE;
            end
        endcase
    end

    // register stage, synchronous active-low reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg     <= CIB_ST_IDLE;
            op_reg        <= CIB_OP_CALL;
            bit_reg       <= '0;
            tgt_reg       <= '0;
            mem_addr_reg  <= '0;
            mem_rd_reg    <= 1'b0;
            mem_wr_reg    <= 1'b0;
            mem_wdata_reg <= '0;
            push_reg      <= 1'b0;
            sdata_reg     <= '0;
            pcld_reg      <= 1'b0;
            pctgt_reg     <= '0;
            wreg_wr_reg   <= 1'b0;
            wreg_wd_reg   <= '0;
            zero_wr_reg   <= 1'b0;
            zero_val_reg  <= 1'b0;
            carry_wr_reg  <= 1'b0;
            carry_val_reg <= 1'b0;
            wdt_clr_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            op_reg        <= op_next;
            bit_reg       <= bit_next;
            tgt_reg       <= tgt_next;
            mem_addr_reg  <= mem_addr_next;
            mem_rd_reg    <= mem_rd_next;
            mem_wr_reg    <= mem_wr_next;
            mem_wdata_reg <= mem_wdata_next;
            push_reg      <= push_next;
            sdata_reg     <= sdata_next;
            pcld_reg      <= pcld_next;
            pctgt_reg     <= pctgt_next;
            wreg_wr_reg   <= wreg_wr_next;
            wreg_wd_reg   <= wreg_wd_next;
            zero_wr_reg   <= zero_wr_next;
            zero_val_reg  <= zero_val_next;
            carry_wr_reg  <= carry_wr_next;
            carry_val_reg <= carry_val_next;
            wdt_clr_reg   <= wdt_clr_next;
        end
    end

    // outputs straight from flops; one clear pulse drives count and both flags
    assign mem_addr           = mem_addr_reg;
    assign mem_rd             = mem_rd_reg;
    assign mem_wr             = mem_wr_reg;
    assign mem_wdata          = mem_wdata_reg;
    assign stack_push         = push_reg;
    assign stack_data         = sdata_reg;
    assign pc_load            = pcld_reg;
    assign pc_target          = pctgt_reg;
    assign wreg_wr            = wreg_wr_reg;
    assign wreg_wdata         = wreg_wd_reg;
    assign zero_wr            = zero_wr_reg;
    assign result_null_flag   = zero_val_reg;
    assign carry_wr           = carry_wr_reg;
    assign carry_next         = carry_val_reg;
    assign watchdog_count_clr = wdt_clr_reg;
    assign expiry_flag_clr    = wdt_clr_reg;
    assign sleep_flag_clr     = wdt_clr_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_call_push_pc: assert property (take && op_code == CIB_OP_CALL |=> stack_push && !pc_load
        && stack_data == $past(pc_now) + `CIB_CALL_PC_INC && !zero_wr && !carry_wr)
        else $error("call push wrong");
    a_call_two_cycles: assert property (take && op_code == CIB_OP_CALL |=> ##1 pc_load && op_done
        && pc_target == $past(op_call_target, 2))
        else $error("call not two cycles");
    a_wipe_byte_zero: assert property (take && op_code == CIB_OP_WIPE_BYTE |=> mem_wr
        && mem_wdata == `CIB_BYTE_ZERO && mem_addr == $past(op_mem_addr) && !zero_wr && !carry_wr)
        else $error("byte wipe wrong");
    a_wipe_bit_only: assert property (take && op_code == CIB_OP_WIPE_BIT |=> ##2 mem_wr
        && mem_wdata == ($past(mem_rdata) & ~(`CIB_BIT_ONE << $past(op_bit_sel, 3))) && !zero_wr)
        else $error("bit wipe wrong");
    a_wdt_clear_all: assert property (take && op_code == CIB_OP_WDT_CLR |=> watchdog_count_clr
        && expiry_flag_clr && sleep_flag_clr && !mem_wr)
        else $error("watchdog clear wrong");
    a_invert_in_place: assert property (state_reg == CIB_ST_EXE && op_reg == CIB_OP_INVERT |=> mem_wr
        && mem_wdata == ~$past(mem_rdata) && zero_wr)
        else $error("invert wrong");
    a_invert_to_wreg: assert property (take && op_code == CIB_OP_INVERT_TO_W |=> ##2 wreg_wr
        && !mem_wr && wreg_wdata == ~$past(mem_rdata) && zero_wr)
        else $error("invert to working register wrong");
    a_bcd_low_digit: assert property (take && op_code == CIB_OP_BCD_ADJUST
        && (working_register[3:0] > `CIB_BCD_DIGIT_MAX || nibble_overflow_flag)
        |=> (mem_wdata - $past(working_register)) == `CIB_BCD_FIX_LO
         || (mem_wdata - $past(working_register)) == `CIB_BCD_FIX_BOTH)
        else $error("low digit not adjusted");
    a_bcd_high_digit: assert property (take && op_code == CIB_OP_BCD_ADJUST
        && (working_register[7:4] > `CIB_BCD_DIGIT_MAX || high_digit_outflow)
        |=> carry_next && ((mem_wdata - $past(working_register)) == `CIB_BCD_FIX_HI
         || (mem_wdata - $past(working_register)) == `CIB_BCD_FIX_BOTH))
        else $error("high digit not adjusted");
    a_bcd_only_carry: assert property (take && op_code == CIB_OP_BCD_ADJUST |=> mem_wr && carry_wr
        && !zero_wr && !wreg_wr && !stack_push)
        else $error("bcd adjust flags wrong");
    a_bcd_no_fix: assert property (take && op_code == CIB_OP_BCD_ADJUST && !nibble_overflow_flag
        && !high_digit_outflow && working_register[7:4] <= `CIB_BCD_DIGIT_MAX
        && working_register[3:0] <= `CIB_BCD_DIGIT_MAX
        |=> mem_wdata == $past(working_register) && !carry_next)
        else $error("valid bcd altered");
    a_null_flag_value: assert property (zero_wr |-> result_null_flag ==
        ((mem_wr ? mem_wdata : wreg_wdata) == `CIB_BYTE_ZERO))
        else $error("zero flag mismatch");

endmodule : cib_exec

`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the call, wipe, watchdog, invert and bcd adjust execution block
`include "cib_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import cib_pkg::*;

    // positions in the packed strobe vector below
    localparam logic [10:0] S_PUSH = 11'h400, S_PCLD = 11'h200, S_MRD = 11'h100, S_MWR = 11'h080;
    localparam logic [10:0] S_WWR = 11'h040, S_ZWR = 11'h020, S_CWR = 11'h010, S_WDT = 11'h00E;
    localparam logic [10:0] S_DONE = 11'h001;

    logic                      clk_sys, rst_b, op_valid, nibble_overflow_flag, high_digit_outflow;
    cib_op_type                op_code;
    logic [`CIB_ADDR_W-1:0]    op_mem_addr;
    logic [`CIB_BIT_SEL_W-1:0] op_bit_sel;
    logic [`CIB_PC_W-1:0]      op_call_target, pc_now, stack_data, pc_target;
    logic [`CIB_DATA_W-1:0]    working_register, mem_rdata, mem_wdata, wreg_wdata;
    logic [`CIB_ADDR_W-1:0]    mem_addr;
    logic                      op_ready, mem_rd, mem_wr, stack_push, pc_load, wreg_wr, zero_wr;
    logic                      result_null_flag, carry_wr, carry_next, op_done;
    logic                      watchdog_count_clr, expiry_flag_clr, sleep_flag_clr;
    logic [7:0]                mem [256];
    wire  [10:0]               strb;
    int                        n_mismatch = 0;
    int                        checks = 0;

    // every strobe in one vector so each cycle is judged whole
    assign strb = {stack_push, pc_load, mem_rd, mem_wr, wreg_wr, zero_wr, carry_wr,
                   watchdog_count_clr, expiry_flag_clr, sleep_flag_clr, op_done};

    cib_exec uut (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_ready(op_ready),
        .op_code(op_code), .op_mem_addr(op_mem_addr), .op_bit_sel(op_bit_sel),
        .op_call_target(op_call_target), .pc_now(pc_now), .working_register(working_register),
        .nibble_overflow_flag(nibble_overflow_flag), .high_digit_outflow(high_digit_outflow),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .stack_push(stack_push), .stack_data(stack_data), .pc_load(pc_load),
        .pc_target(pc_target), .wreg_wr(wreg_wr), .wreg_wdata(wreg_wdata), .zero_wr(zero_wr),
        .result_null_flag(result_null_flag), .carry_wr(carry_wr), .carry_next(carry_next),
        .watchdog_count_clr(watchdog_count_clr), .expiry_flag_clr(expiry_flag_clr),
        .sleep_flag_clr(sleep_flag_clr), .op_done(op_done));

    always #5 clk_sys = ~clk_sys;

    // sync ram, one cycle latency; unread data toggles so a stale sample cannot pass
    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
        if (mem_rd === 1'b1) mem_rdata <= #1 mem[mem_addr];
        else mem_rdata <= #1 ~mem_rdata;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk_strb(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t strobes %h expected %h", $time, got, exp);
        end
    endtask : chk_strb

    task automatic chk_val(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // take one request and judge the strobes of each cycle up to done, then the idle cycle after
    task automatic run_op(input cib_op_type op, input logic [7:0] addr, input logic [10:0] s1,
                          input logic [10:0] s2, input logic [10:0] s3, input int n);
        int k;
        k = 0;
        while (op_ready !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (op_ready !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        op_code = op;
        op_mem_addr = addr;
        op_valid = 1'b1;
        for (k = 1; k <= n; k++) begin
            @(posedge clk_sys);
            #1;
            op_valid = 1'b0;
            chk_strb(strb, (k == 1) ? s1 : (k == 2) ? s2 : s3);
        end
        @(posedge clk_sys);
        #1;
        chk_strb(strb, 11'h000);
        chk_val(13'(op_ready), 13'h0001);
    endtask : run_op

    task automatic t_call(input logic [12:0] pc, input logic [12:0] tgt);
        pc_now = pc;
        op_call_target = tgt;
        run_op(CIB_OP_CALL, 8'h00, S_PUSH, S_PCLD | S_DONE, 11'h000, 2);
        chk_val(stack_data, pc + 13'h0001);
        chk_val(pc_target, tgt);
    endtask : t_call

    task automatic t_wipe_byte(input logic [7:0] addr);
        mem[addr] = 8'hA5;
        run_op(CIB_OP_WIPE_BYTE, addr, S_MWR | S_DONE, 11'h000, 11'h000, 1);
        chk_val(13'(mem[addr]), 13'h0000);
    endtask : t_wipe_byte

    // every bit position, on a byte of all ones and on a mixed pattern
    task automatic t_wipe_bit(input logic [7:0] addr, input logic [7:0] data);
        for (int i = 0; i < 8; i++) begin
            mem[addr] = data;
            op_bit_sel = 3'(i);
            run_op(CIB_OP_WIPE_BIT, addr, S_MRD, 11'h000, S_MWR | S_DONE, 3);
            chk_val(13'(mem[addr]), 13'(data & ~(8'h01 << i)));
        end
    endtask : t_wipe_bit

    task automatic t_wdt();
        run_op(CIB_OP_WDT_CLR, 8'h00, S_WDT | S_DONE, 11'h000, 11'h000, 1);
    endtask : t_wdt

    task automatic t_invert(input logic [7:0] addr, input logic [7:0] data);
        mem[addr] = data;
        run_op(CIB_OP_INVERT, addr, S_MRD, 11'h000, S_MWR | S_ZWR | S_DONE, 3);
        chk_val(13'(mem[addr]), {5'h00, ~data});
        chk_val(13'(result_null_flag), 13'(data == 8'hFF));
    endtask : t_invert

    task automatic t_invert_w(input logic [7:0] addr, input logic [7:0] data);
        mem[addr] = data;
        run_op(CIB_OP_INVERT_TO_W, addr, S_MRD, 11'h000, S_WWR | S_ZWR | S_DONE, 3);
        chk_val(13'(wreg_wdata), {5'h00, ~data});
        chk_val(13'(mem[addr]), 13'(data));
        chk_val(13'(result_null_flag), 13'(data == 8'hFF));
    endtask : t_invert_w

    // expected value built digit by digit; the high fix also sees a carry out of the low fix
    task automatic t_bcd(input logic [7:0] acc, input logic ac, input logic c);
        logic [8:0] t;
        logic       hi;
        t = {1'b0, acc} + ((acc[3:0] > 4'h9 || ac) ? 9'h006 : 9'h000);
        hi = (t[7:4] > 4'h9) || c || t[8];
        t = t + (hi ? 9'h060 : 9'h000);
        working_register = acc;
        nibble_overflow_flag = ac;
        high_digit_outflow = c;
        run_op(CIB_OP_BCD_ADJUST, 8'h30, S_MWR | S_CWR | S_DONE, 11'h000, 11'h000, 1);
        chk_val(13'(mem[8'h30]), 13'(t[7:0]));
        chk_val(13'(carry_next), 13'(hi));
    endtask : t_bcd

    // a second request held while busy must leave no trace until the first is done
    task automatic t_refuse();
        mem[8'h44] = 8'hF0;
        op_bit_sel = 3'h4;
        op_code = CIB_OP_WIPE_BIT;
        op_mem_addr = 8'h44;
        op_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        op_code = CIB_OP_WIPE_BYTE;
        chk_strb(strb, S_MRD);
        chk_val(13'(op_ready), 13'h0000);
        @(posedge clk_sys);
        #1;
        chk_strb(strb, 11'h000);
        @(posedge clk_sys);
        #1;
        op_valid = 1'b0;
        chk_strb(strb, S_MWR | S_DONE);
        @(posedge clk_sys);
        #1;
        chk_strb(strb, 11'h000);
        chk_val(13'(mem[8'h44]), 13'h00E0);
    endtask : t_refuse

    // reset in mid-operation drops every strobe, leaves memory alone, and the block works again
    task automatic t_reset();
        mem[8'h50] = 8'h0F;
        op_code = CIB_OP_INVERT;
        op_mem_addr = 8'h50;
        op_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        op_valid = 1'b0;
        rst_b = 1'b0;
        chk_strb(strb, S_MRD);
        @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        chk_strb(strb, 11'h000);
        chk_val(13'(op_ready), 13'h0001);
        chk_val(13'(mem[8'h50]), 13'h000F);
        t_invert(8'h50, 8'h0F);
    endtask : t_reset

    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        op_valid = 1'b0;
        op_code = CIB_OP_CALL;
        op_mem_addr = 8'h00;
        op_bit_sel = 3'h0;
        op_call_target = 13'h0000;
        pc_now = 13'h0000;
        working_register = 8'h00;
        nibble_overflow_flag = 1'b0;
        high_digit_outflow = 1'b0;
        mem_rdata = 8'h00;
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        chk_strb(strb, 11'h000);
        chk_val(13'(op_ready), 13'h0001);
        t_call(13'h1FFF, 13'h0123);
        t_call(13'h0ABC, 13'h1F00);
        t_wipe_byte(8'hFF);
        t_wipe_bit(8'h10, 8'hFF);
        t_wipe_bit(8'h11, 8'h5A);
        t_wdt();
        t_invert(8'h20, 8'hFF);
        t_invert(8'h21, 8'h3C);
        t_invert_w(8'h22, 8'h00);
        t_invert_w(8'h23, 8'hFF);
        t_bcd(8'h00, 1'b0, 1'b0);
        t_bcd(8'h0A, 1'b0, 1'b0);
        t_bcd(8'h09, 1'b1, 1'b0);
        t_bcd(8'hA0, 1'b0, 1'b0);
        t_bcd(8'h99, 1'b0, 1'b1);
        t_bcd(8'h9A, 1'b0, 1'b0);
        t_bcd(8'h00, 1'b1, 1'b1);
        t_bcd(8'h45, 1'b0, 1'b0);
        t_refuse();
        t_reset();
        stop_test();
    end

endmodule : testbench

`default_nettype wire
